//--- src/cio_pkg.sv
package cio_pkg;
    // port count and widths
    localparam int CIO_NPORTS = 7;
    localparam int CIO_PW = 8;
    localparam int CIO_NPINS = CIO_NPORTS * CIO_PW;
    // index of the four-pin port and its active width
    localparam int CIO_NARROW_PORT = 3;
    localparam int CIO_NARROW_W = 4;
    // first port with a mode-control register (last three ports)
    localparam int CIO_MODE_FIRST = 4;
    // first data-capable port (last two ports)
    localparam int CIO_DATA_FIRST = 5;
    // avalon bus widths
    localparam int CIO_AW = 8;
    localparam int CIO_DW = 32;
    // register groups: byte address = group base + 4 * port index
    localparam logic [7:0] CIO_DIN_BASE = 8'h00;
    localparam logic [7:0] CIO_DOUT_BASE = 8'h20;
    localparam logic [7:0] CIO_DIR_BASE = 8'h40;
    localparam logic [7:0] CIO_MODE_BASE = 8'h60;
    localparam logic [7:0] CIO_MCELL_BASE = 8'h80;
    // reset value of every configuration register
    localparam logic [7:0] CIO_CFG_RESET = 8'h00;
    // answer on unmapped read
    localparam logic [31:0] CIO_UNMAPPED = 32'h0000_0000;
    // readback source select codes
    typedef enum logic [2:0] {
        CIO_SRC_NONE = 3'b000,
        CIO_SRC_DIN = 3'b001,
        CIO_SRC_DOUT = 3'b010,
        CIO_SRC_DIR = 3'b011,
        CIO_SRC_MODE = 3'b100,
        CIO_SRC_MCELL = 3'b101
    } cio_src_t;
endpackage

//--- src/cio_readback.sv
`timescale 1ns/1ps
// encoded readback selector: at most one source drives the internal data bus
module cio_readback
    import cio_pkg::*;
(
    // source select
    input wire cio_pkg::cio_src_t sel,
    // candidate sources
    input wire logic [7:0] din,
    input wire logic [7:0] dout,
    input wire logic [7:0] dir,
    input wire logic [7:0] mode,
    input wire logic [7:0] mcell,
    // selected byte
    output logic [7:0] rdata
);
    // a mux stands in for the tri-state buffer; no internal z is used
    always_comb begin
        case (sel)
            CIO_SRC_DIN: rdata = din;
            CIO_SRC_DOUT: rdata = dout;
            CIO_SRC_DIR: rdata = dir;
            CIO_SRC_MODE: rdata = mode;
            CIO_SRC_MCELL: rdata = mcell;
            default: rdata = 8'h00;
        endcase
    end
endmodule

//--- src/cio_port_block.sv
`timescale 1ns/1ps
// Functional notes
// - seven ports, eight pins, one port four
// - each pin configurable by image or host
// - output mux: data-out, latched address, logic array
// - readback buffer: one source at a time
// - host reads dout, macrocells, dir, mode, pins
// - array, data, address-in, reset modes fixed
// - an assigned pin serves one function only
// - data ports act as host data bus
// - mode bit zero selects microcontroller io
// - direction one output, zero input, anytime
// - output pin driven from data-out bit
// - input pin level readable by host
// - ports without mode register default to io
// - array mode feeds array inputs and outputs
// - upper address pins routed to arrays
// - address inputs optionally latched by strobe
// - memory decode inputs count as address
// - address out needs oe or dir+mode
// - configuration registers reset to zero
// - narrow port has four direction bits
module cio_port_block
    import cio_pkg::*;
#(
    parameter int NPINS = cio_pkg::CIO_NPINS
)(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [cio_pkg::CIO_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [cio_pkg::CIO_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [cio_pkg::CIO_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    // programmed configuration image: four vectors with one bit per pin, then port-wide settings
    input wire logic [NPINS-1:0] cfg_array_io,
    input wire logic [NPINS-1:0] cfg_addr_in,
    input wire logic [NPINS-1:0] cfg_addr_latch,
    input wire logic [NPINS-1:0] cfg_addr_out_oe,
    input wire logic cfg_data_port,
    input wire logic cfg_reset_pattern,
    input wire logic [15:0] reset_pattern,
    input wire logic host_reset_active,
    input wire logic test_port_programming_mode,
    // host bus signals seen by the port logic
    input wire logic address_latch_strobe,
    input wire logic [15:0] latched_address,
    input wire logic [15:0] host_wdata,
    input wire logic host_data_drive,
    output logic [15:0] host_rdata,
    // general logic array
    input wire logic [NPINS-1:0] array_out,
    input wire logic [NPINS-1:0] array_oe,
    input wire logic [NPINS-1:0] mcell_q,
    output logic [NPINS-1:0] array_in,
    output logic [NPINS-1:0] addr_to_array,
    // pins
    input wire logic [NPINS-1:0] pin_i,
    output logic [NPINS-1:0] pin_o,
    output logic [NPINS-1:0] pin_oe
);
    // all state in one packed struct
    typedef struct packed {
        logic [NPINS-1:0] dout;
        logic [NPINS-1:0] dir;
        logic [NPINS-1:0] mode;
        logic [NPINS-1:0] sync1;
        logic [NPINS-1:0] sync2;
        logic [NPINS-1:0] addr_hold;
        logic strobe1;
        logic strobe2;
        logic strobe3; // third stage: compared with the second flop's copy to find the strobe edge
        logic ack;
        logic [7:0] rdata;
    } cio_state_t;

    cio_state_t state_reg; // registered state
    cio_state_t state_next; // next state
    cio_src_t rb_sel; // readback source
    logic [7:0] rb_byte; // readback byte
    logic [2:0] rb_port; // addressed port
    logic [2:0] rb_group; // addressed register group
    logic rb_hit; // address maps to a register
    logic [NPINS-1:0] dir_mask; // implemented direction bits
    logic [NPINS-1:0] mode_mask; // implemented mode bits
    logic [NPINS-1:0] data_mask; // pins of the data ports
    logic [NPINS-1:0] addr_out_en; // address-out selected
    logic [NPINS-1:0] addr_pin_val; // latched address per pin
    logic [NPINS-1:0] addr_live; // address input seen by arrays

    // byte of a pin vector for a port
    function automatic logic [7:0] port_byte(input logic [NPINS-1:0] v, input logic [2:0] p);
        port_byte = v[p*CIO_PW +: CIO_PW];
    endfunction

    // latched address bit for a pin: ports E and F carry a7-a0, G a15-a8
    function automatic logic addr_bit(input logic [15:0] a, input int pin);
        int port;
        int bitn;
        port = pin / CIO_PW;
        bitn = pin % CIO_PW;
        if (port == CIO_NPORTS - 1) begin
            addr_bit = a[bitn + 8];
        end else begin
            addr_bit = a[bitn];
        end
    endfunction

    // masks of implemented bits per port
    always_comb begin
        dir_mask = '1;
        mode_mask = '0;
        data_mask = '0;
        // the narrow port keeps only its low direction bits
        dir_mask[CIO_NARROW_PORT*CIO_PW + CIO_NARROW_W +: CIO_PW - CIO_NARROW_W] = '0;
        mode_mask[NPINS-1 : CIO_MODE_FIRST*CIO_PW] = '1;
        data_mask[NPINS-1 : CIO_DATA_FIRST*CIO_PW] = '1;
    end

    // address decode for the register groups
    always_comb begin
        rb_port = avs_address[4:2];
        rb_group = avs_address[7:5];
        rb_hit = (rb_port < 3'(CIO_NPORTS)) && (rb_group <= 3'(CIO_MCELL_BASE >> 5));
        case (rb_group)
            3'(CIO_DIN_BASE >> 5): rb_sel = CIO_SRC_DIN;
            3'(CIO_DOUT_BASE >> 5): rb_sel = CIO_SRC_DOUT;
            3'(CIO_DIR_BASE >> 5): rb_sel = CIO_SRC_DIR;
            3'(CIO_MODE_BASE >> 5): rb_sel = CIO_SRC_MODE;
            3'(CIO_MCELL_BASE >> 5): rb_sel = CIO_SRC_MCELL;
            default: rb_sel = CIO_SRC_NONE;
        endcase
        if (!rb_hit) begin
            rb_sel = CIO_SRC_NONE;
        end
    end

    // readback buffer, one source at a time
    cio_readback u_readback (
        .sel(rb_sel),
        .din(port_byte(state_reg.sync2, rb_port)),
        .dout(port_byte(state_reg.dout, rb_port)),
        .dir(port_byte(state_reg.dir & dir_mask, rb_port)),
        .mode(port_byte(state_reg.mode & mode_mask, rb_port)),
        .mcell(port_byte(mcell_q, rb_port)),
        .rdata(rb_byte)
    );

    // latched address values and address inputs
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            addr_pin_val[i] = addr_bit(latched_address, i);
        end
        // latched or transparent address inputs to the arrays
        addr_live = (cfg_addr_latch & state_reg.addr_hold) |
            (~cfg_addr_latch & state_reg.sync2);
        addr_to_array = addr_live & cfg_addr_in;
        array_in = (state_reg.sync2 & cfg_array_io & ~cfg_addr_in) |
            addr_to_array;
    end

    // next-state logic: synchronisers, strobe capture, register writes
    always_comb begin
        state_next = state_reg;
        state_next.sync1 = pin_i;
        state_next.sync2 = state_reg.sync1;
        state_next.strobe1 = address_latch_strobe;
        state_next.strobe2 = state_reg.strobe1;
        state_next.strobe3 = state_reg.strobe2;
        // capture address pins on the falling edge of the synchronised strobe
        // the first flop may still be metastable, so the edge is seen one stage later
        if (!state_reg.strobe2 && state_reg.strobe3) begin
            state_next.addr_hold = state_reg.sync2;
        end
        // one wait state: answer on the cycle after the request
        state_next.ack = (avs_read || avs_write) && !state_reg.ack;
        state_next.rdata = rb_byte;
        // a write lands only at the edge where waitrequest is seen low,
        // so a request still in its wait state never touches the registers
        if (avs_write && state_reg.ack && rb_hit && avs_byteenable[0]) begin
            case (rb_sel)
                CIO_SRC_DOUT: state_next.dout[rb_port*CIO_PW +: CIO_PW] = avs_writedata[7:0];
                CIO_SRC_DIR: state_next.dir[rb_port*CIO_PW +: CIO_PW] = avs_writedata[7:0];
                CIO_SRC_MODE: state_next.mode[rb_port*CIO_PW +: CIO_PW] = avs_writedata[7:0];
                default: state_next = state_next;
            endcase
        end
        // fixed modes come only from the image, never from writes
        state_next.dir = state_next.dir & dir_mask;
        state_next.mode = state_next.mode & mode_mask;
    end

    // state register, cleared on reset
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // bus outputs: narrow data in low bits, the rest read as zero
    always_comb begin
        avs_waitrequest = (avs_read || avs_write) && !state_reg.ack;
        avs_readdata = {24'h00_0000, state_reg.rdata};
        if (!rb_hit) begin
            avs_readdata = CIO_UNMAPPED;
        end
    end

    // output multiplexer per pin, one owner per pin
    always_comb begin
        addr_out_en = (state_reg.mode & state_reg.dir & mode_mask) |
            (cfg_addr_out_oe & mode_mask);
        for (int i = 0; i < NPINS; i++) begin
            pin_o[i] = 1'b0;
            pin_oe[i] = 1'b0;
            if (data_mask[i] && cfg_reset_pattern && host_reset_active) begin
                // drive the strap pattern while the host is in reset
                // cast keeps the index inside the sixteen data pins
                pin_o[i] = reset_pattern[4'(i - CIO_DATA_FIRST*CIO_PW)];
                pin_oe[i] = 1'b1;
            end else if (data_mask[i] && cfg_data_port) begin
                pin_o[i] = host_wdata[4'(i - CIO_DATA_FIRST*CIO_PW)];
                pin_oe[i] = host_data_drive;
            end else if (i / CIO_PW == CIO_MODE_FIRST && test_port_programming_mode) begin
                pin_oe[i] = 1'b0; // pins belong to the test port
            end else if (cfg_addr_in[i]) begin
                pin_oe[i] = 1'b0;
            end else if (cfg_array_io[i]) begin
                pin_o[i] = array_out[i];
                pin_oe[i] = array_oe[i] | state_reg.dir[i];
            end else if (addr_out_en[i]) begin
                pin_o[i] = addr_pin_val[i];
                pin_oe[i] = 1'b1;
            end else begin
                pin_o[i] = state_reg.dout[i];
                pin_oe[i] = state_reg.dir[i] & dir_mask[i];
            end
        end
        for (int j = 0; j < 16; j++) begin
            host_rdata[j] = state_reg.sync2[CIO_DATA_FIRST*CIO_PW + j];
        end
    end

    // assertions
    AST_NARROW_DIR: assert property (@(posedge clk) disable iff (reset)
        state_reg.dir[CIO_NARROW_PORT*CIO_PW+7:CIO_NARROW_PORT*CIO_PW+4] == 4'h0)
        else $error("narrow port upper direction bits set");
    AST_NO_MODE_ABC: assert property (@(posedge clk) disable iff (reset)
        state_reg.mode[CIO_MODE_FIRST*CIO_PW-1:0] == '0)
        else $error("mode bits set on port without control");
    AST_RESET_CLEAR: assert property (@(posedge clk)
        $past(reset) |-> (state_reg.dir == '0 && state_reg.mode == '0 && state_reg.dout == '0))
        else $error("configuration not cleared by reset");
    AST_WAIT_ONE: assert property (@(posedge clk) disable iff (reset)
        (avs_read || avs_write) && !state_reg.ack |=> state_reg.ack)
        else $error("no answer one cycle after request");
    AST_DIR_WRITE: assert property (@(posedge clk) disable iff (reset)
        avs_write && !avs_waitrequest && rb_sel == CIO_SRC_DIR && avs_byteenable[0]
        && rb_port == 3'd0 |=> state_reg.dir[7:0] == $past(avs_writedata[7:0]))
        else $error("direction write lost");
    AST_IO_OUT: assert property (@(posedge clk) disable iff (reset)
        !cfg_array_io[0] && !cfg_addr_in[0] && state_reg.dir[0] |-> pin_oe[0]
        && pin_o[0] == state_reg.dout[0])
        else $error("output pin not driven by data-out");
    AST_IO_IN: assert property (@(posedge clk) disable iff (reset)
        !cfg_array_io[0] && !state_reg.dir[0] |-> !pin_oe[0])
        else $error("input pin driven");
    AST_ADDR_IN_QUIET: assert property (@(posedge clk) disable iff (reset)
        cfg_addr_in[8] |-> !pin_oe[8])
        else $error("address input pin driven");
    // a write still in its wait state must leave every register alone
    AST_WRITE_EDGE: assert property (@(posedge clk) disable iff (reset)
        avs_write && avs_waitrequest |=> $stable(state_reg.dout) && $stable(state_reg.dir)
        && $stable(state_reg.mode))
        else $error("write landed before waitrequest went low");
    AST_DOUT_WRITE: assert property (@(posedge clk) disable iff (reset)
        avs_write && !avs_waitrequest && rb_sel == CIO_SRC_DOUT && avs_byteenable[0]
        && rb_port == 3'd0 |=> state_reg.dout[7:0] == $past(avs_writedata[7:0]))
        else $error("data-out write lost");
    // the held address follows the pins seen when the synchronised strobe falls
    AST_ADDR_LATCH: assert property (@(posedge clk) disable iff (reset)
        !state_reg.strobe2 && state_reg.strobe3 |=> state_reg.addr_hold == $past(state_reg.sync2))
        else $error("address not captured on strobe fall");
    AST_DATA_DRIVE: assert property (@(posedge clk) disable iff (reset)
        cfg_data_port && !(cfg_reset_pattern && host_reset_active)
        |-> pin_oe[NPINS-1:CIO_DATA_FIRST*CIO_PW] == {16{host_data_drive}})
        else $error("data port drive does not follow the host");
    AST_TEST_PORT: assert property (@(posedge clk) disable iff (reset)
        test_port_programming_mode |-> pin_oe[CIO_MODE_FIRST*CIO_PW +: CIO_PW] == '0)
        else $error("test port pins driven");
    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (reset)
        avs_read && !rb_hit |-> avs_readdata == CIO_UNMAPPED)
        else $error("unmapped read returned data");
    // address out on the first pin of the first controllable port
    AST_ADDR_OUT: assert property (@(posedge clk) disable iff (reset)
        addr_out_en[CIO_MODE_FIRST*CIO_PW] && !cfg_addr_in[CIO_MODE_FIRST*CIO_PW]
        && !cfg_array_io[CIO_MODE_FIRST*CIO_PW] && !test_port_programming_mode
        |-> pin_oe[CIO_MODE_FIRST*CIO_PW]
        && pin_o[CIO_MODE_FIRST*CIO_PW] == latched_address[0])
        else $error("address out pin not driven by latched address");
endmodule

//--- sim/cio_host_model.sv
`timescale 1ns/1ps
// host bus side: address latch strobe, latched address and data bus drive
module cio_host_model (
    // clock
    input wire logic clk,
    // host bus outputs
    output logic address_latch_strobe,
    output logic [15:0] latched_address,
    output logic [15:0] host_wdata,
    output logic host_data_drive,
    // data seen back from the device
    input wire logic [15:0] host_rdata
);
    initial begin
        address_latch_strobe = 1'b0;
        latched_address = 16'h0000;
        host_wdata = 16'h0000;
        host_data_drive = 1'b0;
    end
    // present an address and pulse the strobe for one cycle
    task put_address(input logic [15:0] a);
        latched_address <= a;
        address_latch_strobe <= 1'b1;
        @(posedge clk);
        address_latch_strobe <= 1'b0;
    endtask
    // drive the data bus for a write cycle
    task drive_data(input logic [15:0] d);
        host_wdata <= d;
        host_data_drive <= 1'b1;
    endtask
    // release: stale data is inverted so a design that still samples it is caught
    task release_data();
        host_data_drive <= 1'b0;
        host_wdata <= ~host_wdata;
    endtask
endmodule

//--- sim/test_cio_port_block.sv
`timescale 1ns/1ps
module test_cio_port_block;
    import cio_pkg::*;
    // clock, reset and avalon master signals
    logic clk, reset, rd_en, wr_en;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic waitreq;
    // image and array side drive
    logic [55:0] cfg_array_io, cfg_addr_in, array_out, array_oe, mcell_q, pin_i;
    logic [55:0] array_in, addr_to_array, pin_o, pin_oe;
    logic cfg_data_port, tpm, ale;
    logic [15:0] lat_a, h_wd, h_rd;
    logic h_drv;
    logic [7:0] got;
    logic [55:0] cfg_addr_latch, cfg_addr_out_oe;
    logic cfg_rp, h_rst;
    logic [15:0] rp;
    int bad_count, total_checks, p;

    cio_port_block u_cio_port_block (.clk(clk), .reset(reset), .avs_address(addr),
        .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
        .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(waitreq),
        .cfg_array_io(cfg_array_io), .cfg_addr_in(cfg_addr_in), .cfg_addr_latch(cfg_addr_latch),
        .cfg_addr_out_oe(cfg_addr_out_oe), .cfg_data_port(cfg_data_port),
        .cfg_reset_pattern(cfg_rp), .reset_pattern(rp), .host_reset_active(h_rst),
        .test_port_programming_mode(tpm), .address_latch_strobe(ale),
        .latched_address(lat_a), .host_wdata(h_wd), .host_data_drive(h_drv),
        .host_rdata(h_rd), .array_out(array_out), .array_oe(array_oe), .mcell_q(mcell_q),
        .array_in(array_in), .addr_to_array(addr_to_array), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe));
    cio_host_model u_cio_host_model (.clk(clk), .address_latch_strobe(ale),
        .latched_address(lat_a), .host_wdata(h_wd), .host_data_drive(h_drv),
        .host_rdata(h_rd));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // compare and count
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon transfer; request held until waitrequest sampled low
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= {24'h000000, d};
        if (w) wr_en <= 1'b1;
        else rd_en <= 1'b1;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        got = rdata[7:0];
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        // an idle edge so a following call never reassigns strobes in one step
        @(posedge clk);
    endtask
    task finish_test();
        if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog well beyond the roughly 150 cycles the tests take
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        finish_test();
    end
    initial begin
        {rd_en, wr_en, cfg_data_port, tpm} = 4'h0;
        {addr, wdata} = '0;
        {cfg_array_io, cfg_addr_in, array_out, array_oe, mcell_q, pin_i} = '0;
        {cfg_addr_latch, cfg_addr_out_oe, rp, cfg_rp, h_rst} = '0;
        bad_count = 0;
        total_checks = 0;
        reset = 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // power-up: data-out and direction registers clear, every pin input
        for (p = 0; p < 7; p++) begin
            xfer(1'b0, CIO_DOUT_BASE + 8'(4 * p), 8'h00);
            chk(got, 8'h00);
            xfer(1'b0, CIO_DIR_BASE + 8'(4 * p), 8'h00);
            chk(got, 8'h00);
        end
        chk(pin_oe, 56'h0);
        // io mode output: direction one drives data-out, zero stays input
        xfer(1'b1, CIO_DIR_BASE, 8'h0F);
        xfer(1'b1, CIO_DOUT_BASE, 8'hA5);
        chk(pin_oe[7:0], 8'h0F);
        chk(pin_o[3:0], 4'h5);
        xfer(1'b0, CIO_DOUT_BASE, 8'h00);
        chk(got, 8'hA5);
        // input level read back through the data-in path
        pin_i[15:8] <= 8'h3C;
        repeat (4) @(posedge clk);
        xfer(1'b0, CIO_DIN_BASE + 8'h04, 8'h00);
        chk(got, 8'h3C);
        // narrow port keeps four direction bits, port A has no mode register
        xfer(1'b1, CIO_DIR_BASE + 8'h0C, 8'hFF);
        xfer(1'b0, CIO_DIR_BASE + 8'h0C, 8'h00);
        chk(got, 8'h0F);
        xfer(1'b1, CIO_MODE_BASE, 8'hFF);
        xfer(1'b0, CIO_MODE_BASE, 8'h00);
        chk(got, 8'h00);
        xfer(1'b0, 8'hA0, 8'h00);
        chk(got, 8'h00);
        // address out on E (low byte) and G (high byte)
        u_cio_host_model.put_address(16'h5A3C);
        xfer(1'b1, CIO_DIR_BASE + 8'h10, 8'hFF);
        xfer(1'b1, CIO_MODE_BASE + 8'h10, 8'hFF);
        chk(pin_o[39:32], 8'h3C);
        xfer(1'b1, CIO_DIR_BASE + 8'h18, 8'hFF);
        xfer(1'b1, CIO_MODE_BASE + 8'h18, 8'hFF);
        chk(pin_o[55:48], 8'h5A);
        xfer(1'b0, CIO_MODE_BASE + 8'h10, 8'h00);
        chk(got, 8'hFF);
        // mode bit back to zero returns the pin to data-out
        xfer(1'b1, CIO_DOUT_BASE + 8'h10, 8'h81);
        xfer(1'b1, CIO_MODE_BASE + 8'h10, 8'h00);
        chk(pin_o[39:32], 8'h81);
        // image output enable selects address out with the mode bit clear
        cfg_addr_out_oe[39:32] <= 8'hFF;
        @(posedge clk);
        chk(pin_o[39:32], 8'h3C);
        chk(pin_oe[39:32], 8'hFF);
        cfg_addr_out_oe[39:32] <= 8'h00;
        // programming mode releases port E
        tpm <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk(pin_oe[39:32], 8'h00);
        tpm <= 1'b0;
        // macrocell readback
        mcell_q[23:16] <= 8'hD2;
        @(posedge clk);
        xfer(1'b0, CIO_MCELL_BASE + 8'h08, 8'h00);
        chk(got, 8'hD2);
        // logic array pins on port C; host leaves their direction clear
        cfg_array_io[23:16] <= 8'hFF;
        array_out[23:16] <= 8'h96;
        array_oe[23:16] <= 8'hF0;
        pin_i[23:16] <= 8'h69;
        cfg_addr_in[7:0] <= 8'hFF;
        pin_i[7:0] <= 8'hC3;
        repeat (4) @(posedge clk);
        chk(pin_o[23:20], 4'h9);
        chk(pin_oe[23:16], 8'hF0);
        chk(array_in[23:16], 8'h69);
        chk(addr_to_array[7:0], 8'hC3);
        // latched address inputs hold the pins seen when the strobe falls
        cfg_addr_latch[7:0] <= 8'hFF;
        u_cio_host_model.put_address(16'h5A3C);
        repeat (5) @(posedge clk);
        pin_i[7:0] <= 8'h11;
        repeat (4) @(posedge clk);
        chk(addr_to_array[7:0], 8'hC3);
        cfg_addr_latch[7:0] <= 8'h00;
        @(posedge clk);
        chk(addr_to_array[7:0], 8'h11);
        // data port on F and G
        cfg_data_port <= 1'b1;
        u_cio_host_model.drive_data(16'hBEEF);
        repeat (2) @(posedge clk);
        chk(pin_o[55:40], 16'hBEEF);
        chk(pin_oe[55:40], 16'hFFFF);
        // strap pattern overrides the data port while the host is held in reset
        rp <= 16'hC0DE;
        cfg_rp <= 1'b1;
        h_rst <= 1'b1;
        @(posedge clk);
        chk(pin_o[55:40], 16'hC0DE);
        h_rst <= 1'b0;
        @(posedge clk);
        chk(pin_o[55:40], 16'hBEEF);
        u_cio_host_model.release_data();
        pin_i[55:40] <= 16'h1234;
        repeat (4) @(posedge clk);
        chk(pin_oe[55:40], 16'h0000);
        chk(h_rd, 16'h1234);
        // reset in mid-run clears the configuration again
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        xfer(1'b0, CIO_DIR_BASE + 8'h10, 8'h00);
        chk(got, 8'h00);
        chk(pin_oe[39:32], 8'h00);
        finish_test();
    end
endmodule
